/* File: mmu_translation_registers.sv */
// translation register set: entry staging, table base, fault capture, control
`timescale 1ns/1ps
`default_nettype none
module mmu_translation_registers
   import mmu_regs_pkg::*;
#(
   parameter logic [31:0] CTRL_SPACE_BASE = 32'hfff0_0000
)(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // control space access from the core
   input  wire logic        acc_req,
   input  wire logic        acc_write,
   input  wire logic        acc_priv,
   input  wire logic [31:0] acc_addr,
   input  wire logic [31:0] acc_wdata,
   output logic             acc_ack,
   output logic             acc_err,
   output logic [31:0]      acc_rdata,
   // exception capture
   input  wire logic        fault_take,
   input  wire logic [31:0] fault_vaddr,
   // entry load instruction
   input  wire logic        load_entry_instruction,
   // translation buffer side
   output logic             tlb_write,
   output tlb_entry_s       tlb_entry,
   output logic             buffer_flush_all,
   output logic [4:0]       tlb_index,
   output logic             mapping_enable,
   output logic             single_space_select,
   output logic             index_hash_select
);
   logic [31:0] high_reg, high_next;
   logic [31:0] low_reg, low_next;
   logic [31:0] base_reg, base_next;
   logic [31:0] fault_reg, fault_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic        ack_reg, ack_next;
   logic        err_reg, err_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        load_reg, load_next;
   logic        flush_reg, flush_next;
   tlb_entry_s  entry_reg, entry_next;
   logic [31:0] offset;
   logic        sel_high, sel_low, sel_base, sel_fault, sel_ctrl;
   logic        hit, ok, wr;

   // address decode; unprivileged requests never reach a register
   assign offset    = acc_addr - CTRL_SPACE_BASE;
   assign sel_high  = acc_req && offset == OFS_ENTRY_HIGH;
   assign sel_low   = acc_req && offset == OFS_ENTRY_LOW;
   assign sel_base  = acc_req && offset == OFS_TABLE_BASE;
   assign sel_fault = acc_req && offset == OFS_FAULT_ADDR;
   assign sel_ctrl  = acc_req && offset == OFS_TRANS_CTRL;
   assign hit = sel_high | sel_low | sel_base | sel_fault | sel_ctrl;
   assign ok  = hit && acc_priv;
   assign wr  = ok && acc_write;

   // register next values; an exception wins over a same-cycle write to the fault register and to high bits 31:10
   always_comb
   begin
      high_next  = high_reg;
      low_next   = low_reg;
      base_next  = base_reg;
      fault_next = fault_reg;
      ctrl_next  = ctrl_reg;
      if (wr && sel_high)
         high_next = acc_wdata & HIGH_MASK;
      if (wr && sel_low)
         low_next = acc_wdata & LOW_MASK;
      if (wr && sel_base)
         base_next = acc_wdata;
      if (wr && sel_fault)
         fault_next = acc_wdata;
      if (wr && sel_ctrl)
         ctrl_next = acc_wdata & CTRL_MASK;
      if (fault_take)
      begin
         // page field takes 22 bits even for small pages
         high_next[31:PAGE_LSB] = fault_vaddr[31:PAGE_LSB];
         fault_next = fault_vaddr;
      end
   end

   // access answer one cycle after the request
   always_comb
   begin
      ack_next   = acc_req;
      err_next   = acc_req && !ok;
      rdata_next = 32'h0000_0000;
      if (ok && !acc_write)
      begin
         if (sel_high)
            rdata_next = high_reg;
         if (sel_low)
            rdata_next = low_reg;
         if (sel_base)
            rdata_next = base_reg;
         if (sel_fault)
            rdata_next = fault_reg;
         if (sel_ctrl)
            rdata_next = ctrl_reg;              // flush bit never stored
      end
   end

   // entry load and flush strobes toward the buffer
   always_comb
   begin
      load_next  = load_entry_instruction;
      flush_next = wr && sel_ctrl && acc_wdata[FLUSH_BIT];
      entry_next = entry_reg;
      if (load_entry_instruction)
      begin
         entry_next.virtual_page_number   = high_reg[31:PAGE_LSB];
         entry_next.process_tag           = high_reg[TAG_MSB:0];
         entry_next.physical_frame_number = low_reg[31:PAGE_LSB];
         entry_next.valid          = low_reg[VALID_BIT];
         entry_next.access_rights  = low_reg[RIGHTS_LSB+1:RIGHTS_LSB];
         entry_next.page_size_code = low_reg[SIZE_BIT];
         entry_next.cacheable      = low_reg[CACHE_BIT];
         entry_next.dirty          = low_reg[DIRTY_BIT];
         entry_next.common_page    = low_reg[COMMON_BIT];
      end
   end

   // state registers
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         high_reg  <= REG_RESET;
         low_reg   <= REG_RESET;
         base_reg  <= REG_RESET;
         fault_reg <= REG_RESET;
         ctrl_reg  <= REG_RESET;
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         load_reg  <= 1'b0;
         flush_reg <= 1'b0;
         entry_reg <= '0;
      end
      else
      begin
         high_reg  <= high_next;
         low_reg   <= low_next;
         base_reg  <= base_next;
         fault_reg <= fault_next;
         ctrl_reg  <= ctrl_next;
         ack_reg   <= ack_next;
         err_reg   <= err_next;
         rdata_reg <= rdata_next;
         load_reg  <= load_next;
         flush_reg <= flush_next;
         entry_reg <= entry_next;
      end
   end

   // outputs; the index follows the high register live
   assign acc_ack          = ack_reg;
   assign acc_err          = err_reg;
   assign acc_rdata        = rdata_reg;
   assign tlb_write        = load_reg;
   assign tlb_entry        = entry_reg;
   assign buffer_flush_all = flush_reg;
   assign mapping_enable      = ctrl_reg[MAP_BIT];
   assign single_space_select = ctrl_reg[SINGLE_BIT];
   assign index_hash_select   = ctrl_reg[HASH_BIT];
   assign tlb_index = ctrl_reg[HASH_BIT]
      ? high_reg[IDX_MSB:IDX_LSB] ^ high_reg[4:0]
      : high_reg[IDX_MSB:IDX_LSB];

   // checks
   property p_unpriv_refused;
      @(posedge mclk) disable iff (sys_rst)
      acc_req && !acc_priv |=> acc_ack && acc_err && acc_rdata == 32'h0;
   endproperty
   a_unpriv_refused: assert property (p_unpriv_refused)
      else $error("unprivileged access not refused");

   property p_fault_page;
      @(posedge mclk) disable iff (sys_rst)
      fault_take |=> high_reg[31:10] == $past(fault_vaddr[31:10]);
   endproperty
   a_fault_page: assert property (p_fault_page)
      else $error("page field not loaded from fault address");

   property p_load_copy;
      @(posedge mclk) disable iff (sys_rst)
      load_entry_instruction && !fault_take && !wr |=>
         tlb_write && tlb_entry.virtual_page_number == high_reg[31:10]
         && tlb_entry.process_tag == high_reg[7:0]
         && tlb_entry.physical_frame_number == low_reg[31:10];
   endproperty
   a_load_copy: assert property (p_load_copy)
      else $error("entry load did not copy staging registers");

   property p_sw_page;
      @(posedge mclk) disable iff (sys_rst)
      wr && sel_high && !fault_take |=> high_reg == $past(acc_wdata & HIGH_MASK);
   endproperty
   a_sw_page: assert property (p_sw_page)
      else $error("software write to high entry lost");

   property p_low_sw_only;
      @(posedge mclk) disable iff (sys_rst)
      !$stable(low_reg) |-> $past(wr && sel_low);
   endproperty
   a_low_sw_only: assert property (p_low_sw_only)
      else $error("low entry changed without a write");

   property p_base_sw_only;
      @(posedge mclk) disable iff (sys_rst)
      !$stable(base_reg) |-> $past(wr && sel_base);
   endproperty
   a_base_sw_only: assert property (p_base_sw_only)
      else $error("table base changed without a write");

   property p_fault_capture;
      @(posedge mclk) disable iff (sys_rst)
      fault_take |=> fault_reg == $past(fault_vaddr);
   endproperty
   a_fault_capture: assert property (p_fault_capture)
      else $error("fault address not captured");

   property p_fault_hold;
      @(posedge mclk) disable iff (sys_rst)
      !fault_take && !(wr && sel_fault) |=> $stable(fault_reg);
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault address changed without exception");

   property p_reserved_zero;
      @(posedge mclk) disable iff (sys_rst)
      (high_reg & ~HIGH_MASK) == 32'h0 && (low_reg & ~LOW_MASK) == 32'h0
         && (ctrl_reg & ~CTRL_MASK) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit set");

   property p_reset_off;
      @(posedge mclk)
      sys_rst |=> !mapping_enable && !single_space_select;
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("translation enabled after reset");

   property p_flush;
      @(posedge mclk) disable iff (sys_rst)
      wr && sel_ctrl && acc_wdata[2] |=> buffer_flush_all ##1
         !buffer_flush_all || $past(wr && sel_ctrl && acc_wdata[2]);
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush strobe wrong");

   property p_index;
      @(posedge mclk) disable iff (sys_rst)
      tlb_index == (high_reg[16:12] ^ (index_hash_select ? high_reg[4:0]
                                                         : 5'h00));
   endproperty
   a_index: assert property (p_index)
      else $error("buffer index wrong");

   c_load: cover property (@(posedge mclk) disable iff (sys_rst)
      load_entry_instruction ##1 tlb_write);
   c_fault: cover property (@(posedge mclk) disable iff (sys_rst)
      fault_take ##[2:40] acc_req && sel_fault && acc_priv);
   c_flush: cover property (@(posedge mclk) disable iff (sys_rst)
      buffer_flush_all);
   c_hash: cover property (@(posedge mclk) disable iff (sys_rst)
      index_hash_select && mapping_enable);
endmodule
`default_nettype wire

/* File: mmu_regs_pkg.sv */
// constants and types shared by the translation register block
package mmu_regs_pkg;
   // register offsets inside the control space window
   localparam logic [31:0] OFS_ENTRY_HIGH  = 32'h0000_0000;
   localparam logic [31:0] OFS_ENTRY_LOW   = 32'h0000_0004;
   localparam logic [31:0] OFS_TABLE_BASE  = 32'h0000_0008;
   localparam logic [31:0] OFS_FAULT_ADDR  = 32'h0000_000c;
   localparam logic [31:0] OFS_TRANS_CTRL  = 32'h0000_0010;
   // writable bits of the high, low and control registers, all others read as zero; then the reset value
   localparam logic [31:0] HIGH_MASK       = 32'hffff_fcff;
   localparam logic [31:0] LOW_MASK        = 32'hffff_fd7e;
   localparam logic [31:0] CTRL_MASK       = 32'h0000_0103;
   localparam logic [31:0] REG_RESET       = 32'h0000_0000;
   // field positions
   localparam int PAGE_LSB   = 10;
   localparam int TAG_MSB    = 7;
   localparam int VALID_BIT  = 8;
   localparam int RIGHTS_LSB = 5;
   localparam int SIZE_BIT   = 4;
   localparam int CACHE_BIT  = 3;
   localparam int DIRTY_BIT  = 2;
   localparam int COMMON_BIT = 1;
   localparam int SINGLE_BIT = 8;
   localparam int FLUSH_BIT  = 2;
   localparam int HASH_BIT   = 1;
   localparam int MAP_BIT    = 0;
   localparam int IDX_LSB    = 12;
   localparam int IDX_MSB    = 16;

   // one translation buffer entry as staged by the load instruction
   typedef struct packed {
      logic [21:0] virtual_page_number;
      logic [7:0]  process_tag;
      logic [21:0] physical_frame_number;
      logic        valid;
      logic [1:0]  access_rights;
      logic        page_size_code;
      logic        cacheable;
      logic        dirty;
      logic        common_page;
   } tlb_entry_s;
endpackage

/* File: core_model.sv */
// core model: software issuing privileged and user mode control space accesses
`timescale 1ns/1ps
`default_nettype none
module core_model
   import mmu_regs_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // request side
   output logic             acc_req,
   output logic             acc_write,
   output logic             acc_priv,
   output logic [31:0]      acc_addr,
   output logic [31:0]      acc_wdata,
   // answer side
   input  wire logic        acc_ack,
   input  wire logic        acc_err,
   input  wire logic [31:0] acc_rdata
);
   // idle bus at time zero
   initial
   begin
      acc_req   = 1'b0;
      acc_write = 1'b0;
      acc_priv  = 1'b0;
      acc_addr  = 32'h0000_0000;
      acc_wdata = 32'h0000_0000;
   end

   // one access: request pulse, answer sampled one edge after it is taken
   // control writes are assumed issued from untranslated fixed space
   task automatic access(input logic w, input logic p, input logic [31:0] a,
                         input logic [31:0] d, output logic [31:0] q,
                         output logic k, output logic e);
      @(posedge mclk);
      acc_req   <= 1'b1;
      acc_write <= w;
      acc_priv  <= p;
      acc_addr  <= a;
      // callers may leave reserved bits set, tag is the process number
      acc_wdata <= d;
      @(posedge mclk);
      acc_req   <= 1'b0;
      // address, data and write lines flip so a stale value cannot pass as held
      acc_addr  <= ~a;
      acc_wdata <= ~d;
      acc_write <= ~w;
      @(posedge mclk);
      q = acc_rdata;
      k = acc_ack;
      e = acc_err;
   endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the translation register block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mmu_regs_pkg::*;
   localparam logic [31:0] BASE = 32'hfff0_0000;
   localparam logic [31:0] OFS [5] = '{OFS_ENTRY_HIGH, OFS_ENTRY_LOW,
      OFS_TABLE_BASE, OFS_FAULT_ADDR, OFS_TRANS_CTRL};
   localparam logic [31:0] MSK [5] = '{HIGH_MASK, LOW_MASK, 32'hffff_ffff,
      32'hffff_ffff, CTRL_MASK};
   logic        mclk, sys_rst, acc_req, acc_write, acc_priv, acc_ack, acc_err;
   logic [31:0] acc_addr, acc_wdata, acc_rdata, fault_vaddr, d, q, v;
   logic        fault_take, load_entry_instruction, tlb_write;
   logic        buffer_flush_all, mapping_enable;
   logic        single_space_select, index_hash_select;
   logic [4:0]  tlb_index;
   tlb_entry_s  tlb_entry;
   logic [31:0] shadow [5];
   int          bad_count, n_checks, j;

   core_model i_core_model (.mclk(mclk), .acc_req(acc_req),
      .acc_write(acc_write), .acc_priv(acc_priv), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_err(acc_err),
      .acc_rdata(acc_rdata));
   mmu_translation_registers #(.CTRL_SPACE_BASE(BASE))
      i_mmu_translation_registers (.mclk(mclk), .sys_rst(sys_rst),
      .acc_req(acc_req), .acc_write(acc_write), .acc_priv(acc_priv),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
      .acc_err(acc_err), .acc_rdata(acc_rdata), .fault_take(fault_take),
      .fault_vaddr(fault_vaddr),
      .load_entry_instruction(load_entry_instruction),
      .tlb_write(tlb_write), .tlb_entry(tlb_entry),
      .buffer_flush_all(buffer_flush_all), .tlb_index(tlb_index),
      .mapping_enable(mapping_enable),
      .single_space_select(single_space_select),
      .index_hash_select(index_hash_select));

   // entry expected from staged high and low words
   function automatic tlb_entry_s exp_entry(input logic [31:0] h, l);
      tlb_entry_s t;
      t = {h[31:10], h[7:0], l[31:10], l[8], l[6:5], l[4], l[3], l[2], l[1]};
      return t;
   endfunction

   // index, hashed with the tag only when the hash bit is set
   function automatic logic [4:0] exp_idx(input logic [31:0] h, c);
      return h[16:12] ^ (c[HASH_BIT] ? h[4:0] : 5'h00);
   endfunction

   task automatic chk(input string what, input logic [63:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", what, e, g);
         bad_count++;
      end
   endtask

   // access with expected answer; a refusal must still be acknowledged
   task automatic rw(input logic w, p, input logic [31:0] a, dd,
                     input logic ee);
      logic k, e;
      i_core_model.access(w, p, a, dd, q, k, e);
      chk("ack", 64'h1, 64'(k));
      chk("err", 64'(ee), 64'(e));
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // clock, 5 ns period
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // watchdog, well beyond the roughly 1400 cycles the run needs
   initial
   begin
      #100000;
      bad_count++;
      tally_and_finish();
   end

   initial
   begin
      sys_rst = 1'b1;
      fault_take = 1'b0;
      fault_vaddr = 32'h0000_0000;
      load_entry_instruction = 1'b0;
      bad_count = 0;
      n_checks = 0;
      void'($urandom(30305));
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         rw(1'b0, 1'b1, BASE + OFS[i], 32'h0, 1'b0);
         shadow[i] = 32'h0;
         chk("reset", 64'h0, 64'(q));
      end
      for (int n = 0; n < 20; n++)
      begin
         j = n % 5;
         // write and read back each register; first pass sets reserved bits
         for (int i = 0; i < 5; i++)
         begin
            d = $urandom() & MSK[i];
            if (n == 0)
               d = 32'hffff_ffff; // corner: every reserved bit set
            if (i == 4)
               d[FLUSH_BIT] = 1'b0; // flush is tried on its own below
            rw(1'b1, 1'b1, BASE + OFS[i], d, 1'b0);
            shadow[i] = d & MSK[i];
            rw(1'b0, 1'b1, BASE + OFS[i], 32'h0, 1'b0);
            chk("reg", 64'(shadow[i]), 64'(q));
         end
         // user mode and unmapped places refused with nothing changed
         rw(1'b1, 1'b0, BASE + OFS[j], ~shadow[j], 1'b1);
         chk("no flush", 64'h0, 64'(buffer_flush_all));
         rw(1'b0, 1'b0, BASE + OFS[j], 32'h0, 1'b1);
         chk("refused data", 64'h0, 64'(q));
         d = BASE + 32'h14 + 32'(4 * n);
         rw(1'b1, 1'b1, d, 32'hffff_ffff, 1'b1);
         chk("map", 64'(shadow[4][MAP_BIT]), 64'(mapping_enable));
         v = shadow[4];
         chk("single", 64'(v[SINGLE_BIT]), 64'(single_space_select));
         chk("hash", 64'(v[HASH_BIT]), 64'(index_hash_select));
         chk("index", 64'(exp_idx(shadow[0], v)), 64'(tlb_index));
         // fault capture, then every register compared
         v = $urandom();
         @(posedge mclk);
         fault_take <= 1'b1;
         fault_vaddr <= v;
         @(posedge mclk);
         fault_take <= 1'b0;
         fault_vaddr <= ~v;
         shadow[0] = {v[31:10], shadow[0][9:0]};
         shadow[3] = v;
         for (int i = 0; i < 5; i++)
         begin
            rw(1'b0, 1'b1, BASE + OFS[i], 32'h0, 1'b0);
            chk("after fault", 64'(shadow[i]), 64'(q));
         end
         // entry load copies staged words, pulse lasts one cycle
         @(posedge mclk);
         load_entry_instruction <= 1'b1;
         @(posedge mclk);
         load_entry_instruction <= 1'b0;
         @(posedge mclk);
         chk("tlb_write", 64'h1, 64'(tlb_write));
         v = shadow[1];
         chk("entry", 64'(exp_entry(shadow[0], v)), 64'(tlb_entry));
         @(posedge mclk);
         chk("tlb_write end", 64'h0, 64'(tlb_write));
         rw(1'b0, 1'b1, BASE + OFS_FAULT_ADDR, 32'h0, 1'b0);
         chk("fault kept", 64'(shadow[3]), 64'(q));
         // flush strobe with the answer, flush bit reads zero
         rw(1'b1, 1'b1, BASE + OFS_TRANS_CTRL, shadow[4] | 32'h4, 1'b0);
         chk("flush", 64'h1, 64'(buffer_flush_all));
         rw(1'b0, 1'b1, BASE + OFS_TRANS_CTRL, 32'h0, 1'b0);
         chk("flush reads", 64'(shadow[4]), 64'(q));
         chk("flush end", 64'h0, 64'(buffer_flush_all));
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
